// file: inc/cif_pkg.sv
// package for the external control input function block
// shared by the top module and its two helpers; no other assumptions
package cif_pkg;

  // register offsets (byte addresses on the apb bus)
  localparam logic [7:0] OFF_SEL   = 8'h00;
  localparam logic [7:0] OFF_CMD   = 8'h04;
  localparam logic [7:0] OFF_STAT  = 8'h08;
  localparam logic [7:0] OFF_MASK  = 8'h0c;
  localparam logic [7:0] OFF_STATE = 8'h10;

  // reset values
  localparam logic [7:0] SEL_RST  = 8'h00;
  localparam logic [3:0] MASK_RST = 4'h0;
  localparam logic [3:0] STAT_RST = 4'h0;

  // command register field
  localparam int unsigned CMD_REMOTE_RESET = 0;

  // trip cause positions
  localparam int unsigned NTRIP    = 5;
  localparam int unsigned TRIP_SC  = 0;
  localparam int unsigned TRIP_EF  = 1;
  localparam int unsigned TRIP_UB  = 2;
  localparam int unsigned TRIP_TH  = 3;
  localparam int unsigned TRIP_ST  = 4;
  localparam logic [4:0] FAULT_MSK = 5'h07;

  // interrupt status positions
  localparam int unsigned NEV      = 4;
  localparam int unsigned EV_TRIP  = 0;
  localparam int unsigned EV_EXT   = 1;
  localparam int unsigned EV_RESET = 2;
  localparam int unsigned EV_STALL = 3;

  // synchronised pins
  localparam int unsigned NPIN    = 3;
  localparam int unsigned PIN_EXT = 0;
  localparam int unsigned PIN_PRG = 1;
  localparam int unsigned PIN_RST = 2;

  // selector switch layout, switch 8 at the top, switch 1 at bit 0
  typedef struct packed {
    logic any_trip_latch_enable;
    logic fault_trip_latch_enable;
    logic external_master_reset_enable;
    logic external_trip_enable;
    logic earth_fault_block_enable;
    logic unbalance_block_enable;
    logic external_restart_inhibit_enable;
    logic speed_switch_stall_enable;
  } cif_cfg_s;

endpackage

// file: rtl/cif_sync.sv
// two flip-flop synchroniser for the pins of the block
// pins are asynchronous to pclk; only the second stage is read outside
`timescale 1ns/10ps
module cif_sync (
  input  wire logic                     pclk,
  input  wire logic                     presetn,
  input  wire logic [cif_pkg::NPIN-1:0] pin_a,
  output logic      [cif_pkg::NPIN-1:0] pin_s
);
  logic [cif_pkg::NPIN-1:0] meta_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_q <= '0;
      pin_s  <= '0;
    end else begin
      meta_q <= pin_a;
      pin_s  <= meta_q;
    end
  end
endmodule

// file: rtl/cif_latch.sv
// trip output holding stage, one bit per trip cause
// a present cause always wins over the clear, so no trip is lost
`timescale 1ns/10ps
module cif_latch (
  input  wire logic                      pclk,
  input  wire logic                      presetn,
  input  wire logic [cif_pkg::NTRIP-1:0] cause,
  input  wire logic [cif_pkg::NTRIP-1:0] latch_en,
  input  wire logic                      clr,
  output logic      [cif_pkg::NTRIP-1:0] trip_q
);
  logic [cif_pkg::NTRIP-1:0] hold;
  logic [cif_pkg::NTRIP-1:0] trip_d;

  // unlatched bits follow their cause; latched ones hold until cleared
  assign hold   = trip_q & latch_en & ~{cif_pkg::NTRIP{clr}};
  assign trip_d = cause | hold;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      trip_q <= '0;
    end else begin
      trip_q <= trip_d;
    end
  end
endmodule

// file: rtl/cif_top.sv
// external control input function and trip latching, apb slave
// pins come in asynchronous; trip causes come from logic on pclk
`timescale 1ns/10ps
module cif_top (
  input  wire logic                      pclk,
  input  wire logic                      presetn,
  input  wire logic                      psel,
  input  wire logic                      penable,
  input  wire logic                      pwrite,
  input  wire logic [7:0]                paddr,
  input  wire logic [31:0]               pwdata,
  output logic      [31:0]               prdata,
  output logic                           pready,
  output logic                           pslverr,
  input  wire logic                      external_control_input,
  input  wire logic                      program_button,
  input  wire logic                      reset_button,
  input  wire logic                      motor_starting,
  input  wire logic [cif_pkg::NTRIP-1:0] trip_cause,
  output logic      [cif_pkg::NTRIP-1:0] trip_out,
  output logic                           trip_relay_a,
  output logic                           stall_indication,
  output logic                           stall_count_stop,
  output logic                           restart_inhibit,
  output logic                           unbalance_block,
  output logic                           earth_fault_block,
  output logic                           unbalance_restart,
  output logic                           earth_fault_restart,
  output logic                           master_reset,
  output logic                           irq
);

  function automatic logic rose(input logic cur, input logic prev);
    return cur & ~prev;
  endfunction

  // pin synchronisation
  logic [cif_pkg::NPIN-1:0] pin_s;
  logic                     ext_s;
  logic                     prg_s;
  logic                     rst_s;

  cif_sync u_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .pin_a   ({reset_button, program_button, external_control_input}),
    .pin_s   (pin_s)
  );

  assign ext_s = pin_s[cif_pkg::PIN_EXT];
  assign prg_s = pin_s[cif_pkg::PIN_PRG];
  assign rst_s = pin_s[cif_pkg::PIN_RST];

  // registers
  logic [7:0]              sel_q;
  logic [cif_pkg::NEV-1:0] mask_q;
  logic [cif_pkg::NEV-1:0] stat_q;
  logic [cif_pkg::NEV-1:0] stat_d;
  logic                    remote_q;
  logic                    ext_prev_q;
  logic                    prg_prev_q;
  logic                    combo_prev_q;
  logic [cif_pkg::NTRIP-1:0] trip_prev_q;
  cif_pkg::cif_cfg_s       cfg;

  // selector register read straight out is the displayed checksum
  assign cfg = cif_pkg::cif_cfg_s'(sel_q);

  // apb decode
  logic setup;
  logic access;
  logic wr;
  logic rd_stat;
  logic a_sel;
  logic a_cmd;
  logic a_stat;
  logic a_mask;
  logic a_state;
  logic mapped;
  logic [31:0] rd_val;
  logic [31:0] state_val;

  assign setup   = psel & ~penable;
  assign access  = psel & penable & pready;
  assign wr      = access & pwrite;
  assign rd_stat = access & ~pwrite & a_stat;
  assign a_sel   = paddr == cif_pkg::OFF_SEL;
  assign a_cmd   = paddr == cif_pkg::OFF_CMD;
  assign a_stat  = paddr == cif_pkg::OFF_STAT;
  assign a_mask  = paddr == cif_pkg::OFF_MASK;
  assign a_state = paddr == cif_pkg::OFF_STATE;
  assign mapped  = a_sel | a_cmd | a_stat | a_mask | a_state;

  assign state_val = {22'h000000, restart_inhibit, stall_count_stop,
                      earth_fault_block, unbalance_block, ext_s, trip_out};

  assign rd_val = a_sel   ? {24'h000000, sel_q} :
                  a_stat  ? {28'h0000000, stat_q} :
                  a_mask  ? {28'h0000000, mask_q} :
                  a_state ? state_val : 32'h00000000;

  // read data is captured in setup so the status snapshot is stable
  logic [31:0] prdata_d;
  assign prdata_d = setup  ? (pwrite ? 32'h00000000 : rd_val) :
                    access ? 32'h00000000 : prdata;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h00000000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      prdata  <= prdata_d;
      pready  <= setup;
      pslverr <= setup & ~mapped;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sel_q    <= cif_pkg::SEL_RST;
      mask_q   <= cif_pkg::MASK_RST;
      remote_q <= 1'b0;
    end else begin
      if (wr && a_sel) begin
        sel_q <= pwdata[7:0];
      end
      if (wr && a_mask) begin
        mask_q <= pwdata[cif_pkg::NEV-1:0];
      end
      remote_q <= wr & a_cmd & pwdata[cif_pkg::CMD_REMOTE_RESET];
    end
  end

  // input functions
  logic ub_blk_d;
  logic ef_blk_d;
  logic ext_trip;
  logic master_d;
  logic stop_d;
  logic prg_rise;
  logic combo_rise;
  logic clr;

  assign ub_blk_d = cfg.unbalance_block_enable & ext_s;
  assign ef_blk_d = cfg.earth_fault_block_enable & ext_s;
  assign ext_trip = cfg.external_trip_enable & ext_s;
  assign master_d = cfg.external_master_reset_enable & ext_s;

  // stop stays until the start-up ends
  assign stop_d = cfg.speed_switch_stall_enable & motor_starting &
                  (stall_count_stop | (ext_s ^ ext_prev_q));

  assign prg_rise   = rose(prg_s, prg_prev_q);
  assign combo_rise = rose(prg_s & rst_s, combo_prev_q);
  assign clr = prg_rise | combo_rise | remote_q | master_d;

  // blocked units see no cause, so a release starts a fresh timing
  logic [cif_pkg::NTRIP-1:0] cause_m;
  logic [cif_pkg::NTRIP-1:0] latch_en;
  logic [cif_pkg::NTRIP-1:0] fault_en;
  logic [cif_pkg::NTRIP-1:0] any_en;

  assign cause_m = trip_cause &
                   ~({4'h0, unbalance_block} << cif_pkg::TRIP_UB) &
                   ~({4'h0, earth_fault_block} << cif_pkg::TRIP_EF);
  assign fault_en = {cif_pkg::NTRIP{cfg.fault_trip_latch_enable}} & cif_pkg::FAULT_MSK;
  assign any_en   = {cif_pkg::NTRIP{cfg.any_trip_latch_enable}};
  assign latch_en = fault_en | any_en;

  cif_latch u_latch (
    .pclk     (pclk),
    .presetn  (presetn),
    .cause    (cause_m),
    .latch_en (latch_en),
    .clr      (clr),
    .trip_q   (trip_out)
  );

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stall_indication    <= 1'b0;
      stall_count_stop    <= 1'b0;
      restart_inhibit     <= 1'b0;
      unbalance_block     <= 1'b0;
      earth_fault_block   <= 1'b0;
      unbalance_restart   <= 1'b0;
      earth_fault_restart <= 1'b0;
      master_reset        <= 1'b0;
      trip_relay_a        <= 1'b0;
    end else begin
      stall_indication    <= cfg.speed_switch_stall_enable & ext_s;
      stall_count_stop    <= stop_d;
      restart_inhibit     <= cfg.external_restart_inhibit_enable & ext_s;
      unbalance_block     <= ub_blk_d;
      earth_fault_block   <= ef_blk_d;
      unbalance_restart   <= unbalance_block & ~ub_blk_d;
      earth_fault_restart <= earth_fault_block & ~ef_blk_d;
      master_reset        <= master_d;
      // external trips bypass the trip record entirely
      trip_relay_a        <= ext_trip | (|trip_out);
    end
  end

  // interrupts: sticky events cleared by reading the status register
  logic [cif_pkg::NEV-1:0] ev;
  logic [cif_pkg::NEV-1:0] rd_clr;

  assign ev[cif_pkg::EV_TRIP]  = |(trip_out & ~trip_prev_q);
  assign ev[cif_pkg::EV_EXT]   = rose(ext_s, ext_prev_q);
  assign ev[cif_pkg::EV_RESET] = clr;
  assign ev[cif_pkg::EV_STALL] = stop_d & ~stall_count_stop;

  // only bits that were actually returned are cleared; set wins
  assign rd_clr = rd_stat ? prdata[cif_pkg::NEV-1:0] : cif_pkg::STAT_RST;
  assign stat_d = (stat_q & ~rd_clr) | ev;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stat_q       <= cif_pkg::STAT_RST;
      irq          <= 1'b0;
      ext_prev_q   <= 1'b0;
      prg_prev_q   <= 1'b0;
      combo_prev_q <= 1'b0;
      trip_prev_q  <= '0;
    end else begin
      stat_q       <= stat_d;
      irq          <= |(stat_d & mask_q);
      ext_prev_q   <= ext_s;
      prg_prev_q   <= prg_s;
      combo_prev_q <= prg_s & rst_s;
      trip_prev_q  <= trip_out;
    end
  end

  // checks

  property p_stall;
    @(posedge pclk) disable iff (!presetn)
    (cfg.speed_switch_stall_enable && ext_s) |=> stall_indication;
  endproperty
  a_stall: assert property (p_stall) else $error("stall indication missing");

  property p_restart;
    @(posedge pclk) disable iff (!presetn)
    restart_inhibit |-> $past(cfg.external_restart_inhibit_enable) && $past(ext_s);
  endproperty
  a_restart: assert property (p_restart) else $error("restart inhibit without cause");

  property p_ub_block;
    @(posedge pclk) disable iff (!presetn)
    (cfg.unbalance_block_enable && ext_s) |=> unbalance_block && !cause_m[cif_pkg::TRIP_UB];
  endproperty
  a_ub_block: assert property (p_ub_block) else $error("unbalance not blocked");

  property p_ef_block;
    @(posedge pclk) disable iff (!presetn)
    (cfg.earth_fault_block_enable && ext_s) |=> earth_fault_block;
  endproperty
  a_ef_block: assert property (p_ef_block) else $error("earth fault not blocked");

  property p_release;
    @(posedge pclk) disable iff (!presetn)
    $fell(unbalance_block) |-> unbalance_restart;
  endproperty
  a_release: assert property (p_release) else $error("no restart pulse on deblock");

  property p_ext_trip;
    @(posedge pclk) disable iff (!presetn)
    (cfg.external_trip_enable && ext_s) |=> trip_relay_a;
  endproperty
  a_ext_trip: assert property (p_ext_trip) else $error("external trip not on relay a");

  property p_unlatched;
    @(posedge pclk) disable iff (!presetn)
    (latch_en == 5'h00 && cause_m == 5'h00) |=> trip_out == 5'h00;
  endproperty
  a_unlatched: assert property (p_unlatched) else $error("trip held without latching");

  sequence s_fault_held;
    trip_out[cif_pkg::TRIP_SC] && cfg.fault_trip_latch_enable && !clr;
  endsequence

  property p_latched;
    @(posedge pclk) disable iff (!presetn)
    s_fault_held |=> trip_out[cif_pkg::TRIP_SC];
  endproperty
  a_latched: assert property (p_latched) else $error("latched fault trip dropped");

  sequence s_remote_clear;
    remote_q && trip_cause == 5'h00;
  endsequence

  property p_clear;
    @(posedge pclk) disable iff (!presetn)
    s_remote_clear |=> trip_out == 5'h00 ##1 trip_relay_a == 1'b0 || $past(ext_trip);
  endproperty
  a_clear: assert property (p_clear) else $error("remote reset did not clear");

  property p_irq;
    @(posedge pclk) disable iff (!presetn)
    |(stat_q & mask_q) |-> irq || $past(rd_stat) || $changed(mask_q);
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt missing");

endmodule

// file: testbench/cif_field.sv
// field side model: speed switch or external relay contact, and the two buttons
// assumes pclk from the bench; every pin moves just after a rising edge
`timescale 1ns/10ps
module cif_field (
  input  wire logic pclk,
  input  wire logic want_ext,
  input  wire logic want_prg,
  input  wire logic want_rst,
  output logic      ext_pin = 1'b0,
  output logic      prg_pin = 1'b0,
  output logic      rst_pin = 1'b0
);
  // the external relay reports its trips on ext_pin, the same contact, which cif_top turns into an external trip on switch 5
  always @(posedge pclk) begin
    ext_pin <= want_ext;
    prg_pin <= want_prg;
    rst_pin <= want_rst;
  end
endmodule

// file: testbench/cif_top_tb.sv
// self-checking bench for cif_top: apb master, field model, trip cause driver
// waits for pready in every access, so wait states are accepted; read results are checked by a watcher
`timescale 1ns/10ps
module cif_top_tb;
  logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, seed = 32'h5882;
  logic        pready, pslverr, external_control_input, program_button, reset_button;
  logic        want_ext = 1'b0, want_prg = 1'b0, want_rst = 1'b0, motor_starting = 1'b0;
  logic [4:0]  trip_cause = 5'h00, trip_out, texp;
  logic        trip_relay_a, stall_indication, stall_count_stop, restart_inhibit, unbalance_block;
  logic        earth_fault_block, unbalance_restart, earth_fault_restart, master_reset, irq;
  logic [5:0]  fn;
  logic [7:0]  cfg;
  logic [33:0] exp_q[$];
  logic [33:0] we;
  int          bad_count = 0, n_tests = 0, cyc = 0, pulses;

  // one bit per selector switch 1..6, so the expected pattern is the selector itself
  assign fn = {master_reset, trip_relay_a, earth_fault_block, unbalance_block, restart_inhibit, stall_indication};

  cif_top i_cif_top (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .external_control_input, .program_button, .reset_button, .motor_starting, .trip_cause,
    .trip_out, .trip_relay_a, .stall_indication, .stall_count_stop, .restart_inhibit,
    .unbalance_block, .earth_fault_block, .unbalance_restart, .earth_fault_restart,
    .master_reset, .irq
  );

  cif_field i_cif_field (
    .pclk, .want_ext, .want_prg, .want_rst,
    .ext_pin(external_control_input), .prg_pin(program_button), .rst_pin(reset_button)
  );

  initial begin
    forever #25 pclk = ~pclk;
  end

  function automatic logic [31:0] xs(input logic [31:0] x);
    logic [31:0] y;
    y = x ^ (x << 13);
    y = y ^ (y >> 17);
    return y ^ (y << 5);
  endfunction

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    n_tests++;
    if (s !== e) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", nm, e, s);
    end
  endtask

  task automatic finish_test();
    if (bad_count == 0 && n_tests > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // e carries {ignore, error, data}; reads leave it on the queue for the watcher
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [33:0] e);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    if (!w) exp_q.push_back(e);
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 34'h0);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic err);
    apb(1'b0, a, 32'h0, {1'b0, err, e});
  endtask

  task automatic trip(input logic [4:0] c);
    trip_cause <= c;
    repeat (2) @(posedge pclk);
    trip_cause <= 5'h00;
    repeat (3) @(posedge pclk);
  endtask

  // 0 program, 1 program with reset, 2 remote command, 3 external input as reset
  task automatic clr(input int m);
    if (m == 2) wr(cif_pkg::OFF_CMD, 32'h1);
    else begin
      if (m == 3) wr(cif_pkg::OFF_SEL, {24'h0, cfg | 8'h20});
      want_prg <= (m != 3);
      want_rst <= (m == 1);
      want_ext <= (m == 3);
      repeat (6) @(posedge pclk);
      want_prg <= 1'b0;
      want_rst <= 1'b0;
      want_ext <= 1'b0;
      if (m == 3) wr(cif_pkg::OFF_SEL, {24'h0, cfg});
    end
    repeat (6) @(posedge pclk);
  endtask

  always @(posedge pclk) begin
    cyc++;
    if (psel && penable && pready === 1'b1 && !pwrite && exp_q.size() > 0) begin
      we = exp_q.pop_front();
      if (!we[33]) begin
        chk("prdata", we[31:0], prdata);
        chk("pslverr", 32'(we[32]), 32'(pslverr));
      end
    end
    if (cyc == 20000) begin
      bad_count++;
      finish_test();
    end
  end

  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    rd(cif_pkg::OFF_SEL, 32'h0, 1'b0);
    rd(cif_pkg::OFF_MASK, 32'h0, 1'b0);
    rd(8'h14, 32'h0, 1'b1);
    for (int n = 0; n < 12; n++) begin
      seed = xs(seed);
      if (n < 8) seed = 32'h1 << n;
      wr(cif_pkg::OFF_SEL, seed);
      rd(cif_pkg::OFF_SEL, {24'h0, seed[7:0]}, 1'b0);
    end
    for (int k = 0; k < 6; k++) begin
      wr(cif_pkg::OFF_SEL, 32'h1 << k);
      motor_starting <= 1'b1;
      want_ext <= 1'b1;
      repeat (6) @(posedge pclk);
      chk("functions", 32'(6'h1 << k), 32'(fn));
      chk("stall_count_stop", 32'(k == 0), 32'(stall_count_stop));
      rd(cif_pkg::OFF_STATE, {22'h0, k == 1, k == 0, k == 3, k == 2, 1'b1, 5'h00}, 1'b0);
      // a blocked unit must not see its cause while the input stands
      trip_cause <= 5'h06;
      repeat (2) @(posedge pclk);
      chk("blocked trip_out", 32'(5'h06 & ~{2'b00, k == 2, k == 3, 1'b0}), 32'(trip_out));
      trip_cause <= 5'h00;
      want_ext <= 1'b0;
      pulses = 0;
      repeat (8) begin
        @(posedge pclk);
        pulses += unbalance_restart + earth_fault_restart;
      end
      chk("restart pulses", (k == 2 || k == 3) ? 1 : 0, pulses);
      chk("functions off", 32'h0, 32'(fn));
      motor_starting <= 1'b0;
    end
    for (int i = 0; i < 3; i++) begin
      cfg = 8'h40 * i;
      wr(cif_pkg::OFF_SEL, {24'h0, cfg});
      for (int c = 0; c < 5; c++) begin
        trip(5'h1 << c);
        texp = (i == 2 || (i == 1 && c < 3)) ? 5'h1 << c : 5'h00;
        chk("trip_out", 32'(texp), 32'(trip_out));
        chk("trip_relay_a", 32'(|texp), 32'(trip_relay_a));
        clr(c % 4);
        chk("trip_out cleared", 32'h0, 32'(trip_out));
      end
    end
    wr(cif_pkg::OFF_SEL, 32'h0);
    apb(1'b0, cif_pkg::OFF_STAT, 32'h0, {1'b1, 33'h0});
    for (int m = 1; m >= 0; m--) begin
      wr(cif_pkg::OFF_MASK, 32'(m));
      trip(5'h01);
      chk("irq", 32'(m), 32'(irq));
      rd(cif_pkg::OFF_STAT, 32'h1, 1'b0);
      repeat (2) @(posedge pclk);
      chk("irq after read", 32'h0, 32'(irq));
    end
    chk("pending reads", 32'h0, 32'(exp_q.size()));
    finish_test();
  end
endmodule
